/* core_ops_pkg.sv */
// Shared constants and carrier types for the negate and return-stack execution block.
package core_ops_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W = 21;
  localparam int unsigned STACK_DEPTH = 31;
  localparam int unsigned SP_W = 5;

  localparam logic [15:0] NEG_MASK = 16'hfe00;
  localparam logic [15:0] NEG_MATCH = 16'h6c00;
  localparam int unsigned ACCESS_BIT = 8;
  localparam logic [15:0] POP_CODE = 16'h0006;
  localparam logic [15:0] PUSH_CODE = 16'h0005;

  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [SP_W-1:0] SP_RESET = 5'h00;
  localparam logic [SP_W-1:0] SP_ONE = 5'h01;
  localparam logic [1:0] Q_LAST = 2'h3;

  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_DIGIT_CARRY = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OVERFLOW = 3;
  localparam int unsigned FLAG_N = 4;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_NEGATE,
    OP_POP,
    OP_PUSH
  } op_kind_t;

  typedef struct packed {
    logic c;
    logic digit_carry_flag;
    logic z;
    logic overflow_flag;
    logic n;
  } status_flags_t;

  typedef struct packed {
    logic [15:0] word;
    logic [PC_W-1:0] pc;
    logic valid;
  } instr_in_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } data_write_t;

endpackage

/* negate_unit.sv */
// Two's complement negation with arithmetic status flag generation.
`timescale 1ns/1ns
module negate_unit
  import core_ops_pkg::*;
(
  // Operand
  input wire logic [DATA_W-1:0] operand,
  // Result
  output logic [DATA_W-1:0] result,
  output status_flags_t flags
);

  logic [DATA_W:0] sum;
  logic [4:0] low_sum;

  // Negation is computed as the inverse plus one so carries match a real subtract.
  always_comb begin
    sum = {1'b0, ~operand} + {{DATA_W{1'b0}}, 1'b1};
    low_sum = {1'b0, ~operand[3:0]} + 5'h01;
    result = sum[DATA_W-1:0];
    flags.c = sum[DATA_W];
    flags.digit_carry_flag = low_sum[4];
    flags.z = (sum[DATA_W-1:0] == '0);
    flags.n = sum[DATA_W-1];
    flags.overflow_flag = operand[DATA_W-1] & sum[DATA_W-1];
  end

endmodule

/* negate_and_stack_ops.sv */
// Execution of the negate-file, pop and push instructions of an 8-bit core.
`timescale 1ns/1ns
module negate_and_stack_ops
  import core_ops_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction from fetch, presented for a whole instruction cycle
  input wire instr_in_t instr,
  input wire logic [1:0] q_phase,
  // Addressing context
  input wire logic [3:0] bank_select_reg,
  input wire logic extended_set_en,
  input wire logic [ADDR_W-1:0] index_base,
  // Data memory
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  output data_write_t mem_wr,
  // Status and stack
  output status_flags_t status_q,
  output logic status_we,
  output logic [PC_W-1:0] top_of_stack_entry,
  output logic [SP_W-1:0] stack_ptr,
  output logic stack_overflow,
  output logic stack_underflow
);

  function automatic op_kind_t decode_op(input logic [15:0] w);
    if ((w & NEG_MASK) == NEG_MATCH) begin
      decode_op = OP_NEGATE;
    end else if (w == POP_CODE) begin
      decode_op = OP_POP;
    end else if (w == PUSH_CODE) begin
      decode_op = OP_PUSH;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction

  // The access bit wins over the extended set: indexed mode only replaces the low access range, offsets up to 8'h5f.
  // Bank, access and indexed modes all resolve to one 12-bit address here.
  function automatic logic [ADDR_W-1:0] file_addr(input logic [15:0] w, input logic [3:0] bank_sel,
                                                  input logic ext, input logic [ADDR_W-1:0] base);
    logic [7:0] f;
    f = w[7:0];
    if (w[ACCESS_BIT]) begin
      file_addr = {bank_sel, f};
    end else if (ext && f <= INDEXED_LIMIT) begin
      file_addr = base + {4'h0, f};
    end else if (f <= ACCESS_LOW_LIMIT) begin
      file_addr = {4'h0, f};
    end else begin
      file_addr = {ACCESS_HIGH_BANK, f};
    end
  endfunction

  // Return stack below the top entry: slot n-1 holds the n-th entry counted up from the bottom.
  // The top itself lives in a register so pop and push never wait on the array.
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];

  // Decode.
  op_kind_t op;
  logic commit;

  // Operand address.
  logic [ADDR_W-1:0] addr_q, addr_d;

  // Write-back and status.
  data_write_t wr_q, wr_d;
  status_flags_t stat_q, stat_d;
  logic stat_we_q, stat_we_d;
  logic [DATA_W-1:0] neg_result;
  status_flags_t neg_flags;

  // Return stack.
  logic [PC_W-1:0] top_q, top_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic ovf_q, ovf_d, unf_q, unf_d;
  logic push_mem;
  logic stack_full;
  logic stack_empty;
  logic [SP_W-1:0] below_idx;

  negate_unit u_negate (
    .operand(rd_data),
    .result(neg_result),
    .flags(neg_flags)
  );

  // The word is held for the whole instruction cycle, so decode is combinational.
  // Everything commits in the last quarter so decode and the operand read settle first.
  always_comb begin
    op = instr.valid ? decode_op(instr.word) : OP_NONE;
    commit = (q_phase == Q_LAST);
  end

  // The address is latched on every edge while a negate is decoded, first at the end of the first quarter, giving the read three cycles to return.
  always_comb begin
    addr_d = addr_q;
    if (op == OP_NEGATE) begin
      addr_d = file_addr(instr.word, bank_select_reg, extended_set_en,
                         index_base);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  // The result goes back to the address it was read from, as a one-cycle pulse.
  // A negate straight after reads in its last quarter, well after this pulse has landed.
  always_comb begin
    wr_d = '0;
    stat_d = stat_q;
    stat_we_d = 1'b0;
    if (commit && op == OP_NEGATE) begin
      wr_d.write = 1'b1;
      wr_d.addr = addr_q;
      wr_d.data = neg_result;
      stat_d = neg_flags;
      stat_we_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      stat_q <= '0;
      stat_we_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      stat_q <= stat_d;
      stat_we_q <= stat_we_d;
    end
  end

  // A push on a full stack and a pop on an empty one change nothing but raise a
  // sticky flag, which only reset clears, so the fault can still be found later.
  // An empty stack shows zero as its top.
  always_comb begin
    stack_full = (sp_q == SP_W'(STACK_DEPTH));
    stack_empty = (sp_q == SP_RESET);
    below_idx = sp_q - SP_ONE - SP_ONE;
    top_d = top_q;
    sp_d = sp_q;
    ovf_d = ovf_q;
    unf_d = unf_q;
    push_mem = 1'b0;
    if (commit) begin
      unique case (op)
        OP_PUSH: begin
          if (stack_full) begin
            ovf_d = 1'b1;
          end else begin
            push_mem = !stack_empty;
            top_d = instr.pc + PC_STEP;
            sp_d = sp_q + SP_ONE;
          end
        end
        OP_POP: begin
          if (stack_empty) begin
            unf_d = 1'b1;
          end else begin
            sp_d = sp_q - SP_ONE;
            top_d = (sp_q == SP_ONE) ? '0 : stack_mem[below_idx];
          end
        end
        OP_NEGATE, OP_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_q <= '0;
      sp_q <= SP_RESET;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      top_q <= top_d;
      sp_q <= sp_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
    end
  end

  // The old top sinks into the array as the new one takes its place.
  // The array needs no reset: nothing below the top is read until it has been written.
  always_ff @(posedge ref_clk) begin
    if (push_mem) begin
      stack_mem[sp_q - SP_ONE] <= top_q;
    end
  end

  // Every output is a plain copy of a register.
  always_comb begin
    rd_addr = addr_q;
    mem_wr = wr_q;
    status_q = stat_q;
    status_we = stat_we_q;
    top_of_stack_entry = top_q;
    stack_ptr = sp_q;
    stack_overflow = ovf_q;
    stack_underflow = unf_q;
  end

endmodule

/* data_mem_model.sv */
// Behavioural data memory facing the block: reads answer at once, writes land on the pulse.
`timescale 1ns/1ns
module data_mem_model
  import core_ops_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Memory side
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire data_write_t mem_wr
);
  logic [DATA_W-1:0] mem [0:4095];
  assign rd_data = mem[rd_addr];
  always @(posedge ref_clk) begin
    if (mem_wr.write) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule

/* negate_and_stack_ops_props.sv */
// Concurrent checks on the negate and return-stack execution block.
`timescale 1ns/1ns
module negate_and_stack_ops_props
  import core_ops_pkg::*;
(
  // Clock, reset and instruction
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire instr_in_t instr,
  input wire logic [1:0] q_phase,
  // Results
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire data_write_t mem_wr,
  input wire status_flags_t status_q,
  input wire logic status_we,
  input wire logic [PC_W-1:0] top_of_stack_entry,
  input wire logic [SP_W-1:0] stack_ptr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic commit = q_phase == Q_LAST && instr.valid;
  a_write_pulse: assert property (mem_wr.write |=> !mem_wr.write)
    else $error("write pulse too long");
  a_write_value: assert property (mem_wr.write |->
    mem_wr.data == DATA_W'(~$past(rd_data) + 1'b1)) else $error("bad negation");
  a_write_addr: assert property (mem_wr.write |-> mem_wr.addr == $past(rd_addr))
    else $error("write address differs from read");
  a_flag_strobe: assert property (status_we == mem_wr.write)
    else $error("flag strobe apart from write");
  a_zero_sign: assert property (status_we |-> status_q.z == (mem_wr.data == 8'h00)
    && status_q.n == mem_wr.data[7]) else $error("bad zero or sign flag");
  a_flags_hold: assert property (!status_we |-> $stable(status_q))
    else $error("flags moved without negate");
  a_push_top: assert property (commit && instr.word == PUSH_CODE && stack_ptr != 5'h1f |=>
    top_of_stack_entry == $past(instr.pc) + PC_STEP && stack_ptr == $past(stack_ptr) + SP_ONE)
    else $error("push result wrong");
  a_pop_depth: assert property (commit && instr.word == POP_CODE && stack_ptr != 5'h00 |=>
    stack_ptr == $past(stack_ptr) - SP_ONE) else $error("pop depth wrong");
  a_idle_depth: assert property (!commit |=> $stable(stack_ptr))
    else $error("stack moved outside commit");
endmodule
bind negate_and_stack_ops negate_and_stack_ops_props u_props (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .instr(instr),
  .q_phase(q_phase),
  .rd_addr(rd_addr),
  .rd_data(rd_data),
  .mem_wr(mem_wr),
  .status_q(status_q),
  .status_we(status_we),
  .top_of_stack_entry(top_of_stack_entry),
  .stack_ptr(stack_ptr)
);

/* negate_and_stack_ops_test.sv */
// Self-checking bench for the negate and return-stack execution block.
`timescale 1ns/1ns
module negate_and_stack_ops_test;
  import core_ops_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  instr_in_t instr = '0;
  logic [1:0] q_phase = 2'h0;
  logic [3:0] bank_select_reg = 4'h0;
  logic extended_set_en = 1'b0;
  logic [ADDR_W-1:0] index_base = 12'h000;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  data_write_t mem_wr;
  logic [PC_W-1:0] top_of_stack_entry;
  logic [SP_W-1:0] stack_ptr;
  logic stack_overflow;
  logic stack_underflow;
  int failures = 0;
  int num_checks = 0;
  integer seed = 32'hdc9e0039;
  logic [24:0] notes [$];
  logic [26:0] seen_wr;
  logic [PC_W-1:0] stk [$];
  logic [7:0] f;
  logic [7:0] v;
  logic [7:0] r;
  status_flags_t status_q;
  logic status_we;
  logic [ADDR_W-1:0] a;
  int m;
  negate_and_stack_ops DUT (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr),
    .q_phase(q_phase), .bank_select_reg(bank_select_reg), .extended_set_en(extended_set_en),
    .index_base(index_base), .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr),
    .status_q(status_q), .status_we(status_we), .top_of_stack_entry(top_of_stack_entry),
    .stack_ptr(stack_ptr), .stack_overflow(stack_overflow), .stack_underflow(stack_underflow));
  data_mem_model mem_i (.ref_clk(ref_clk), .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One instruction cycle, then an idle word; the task returns as the idle cycle starts, with the results already registered.
  task automatic run(input logic [15:0] w, input logic [PC_W-1:0] pc);
    for (int q = 0; q < 5; q++) begin
      @(negedge ref_clk);
      instr = {w, pc, q < 4};
      q_phase = 2'(q);
    end
  endtask
  always @(negedge ref_clk) begin
    if (mem_wr.write === 1'b1 || status_we === 1'b1) begin
      seen_wr = {mem_wr.write, status_we, mem_wr.addr, mem_wr.data, status_q};
      check("write", seen_wr, {2'b11, notes.pop_front()});
    end
  end
  initial begin
    #20000;
    failures++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 48; i++) begin
      // Let the previous write-back land before the next operand is planted.
      @(negedge ref_clk);
      m = i % 4;
      f = 8'($random(seed));
      f = (m == 1 || m == 2) ? f % 8'h60 : (m == 3 ? f | 8'h80 : f);
      f = (i == 5 || i == 6) ? 8'h5f : (i == 7 ? 8'h60 : f);
      v = (i == 0) ? 8'h00 : (i == 1 ? 8'h80 : 8'($random(seed)));
      bank_select_reg = 4'($random(seed));
      index_base = 12'($random(seed));
      extended_set_en = m >= 2;
      a = m == 0 ? {bank_select_reg, f} : (m == 2 ? index_base + f :
        (f <= 8'h5f ? {4'h0, f} : {4'hf, f}));
      r = ~v + 8'h01;
      mem_i.mem[a] = v;
      notes.push_back({a, r, v == 8'h00, v[3:0] == 4'h0, r == 8'h00, v == 8'h80, r[7]});
      run({7'b0110110, m == 0, f}, 21'(i));
    end
    @(negedge ref_clk);
    check("notes left", notes.size(), 0);
    $display("negate test done");
    for (int i = 0; i < 32; i++) begin
      run(PUSH_CODE, 21'(i * 8));
      if (i < 31) stk.push_back(21'(i * 8 + 2));
      check("push top", top_of_stack_entry, stk[$]);
      check("push depth", stack_ptr, stk.size());
    end
    check("overflow", stack_overflow, 1);
    for (int i = 0; i < 32; i++) begin
      run(POP_CODE, 21'h0);
      if (stk.size() > 0) void'(stk.pop_back());
      check("pop top", top_of_stack_entry, stk.size() > 0 ? stk[$] : 0);
      check("pop depth", stack_ptr, stk.size());
    end
    check("underflow", stack_underflow, 1);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    check("reset", {stack_overflow, stack_underflow, stack_ptr}, 0);
    run(PUSH_CODE, 21'h000040);
    check("push after reset", top_of_stack_entry, 21'h000042);
    check("depth after reset", stack_ptr, 1);
    $display("stack test done");
    test_done();
  end
endmodule
